/* hw/rcg_pkg.sv */
package rcg_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  localparam int BYTE_SHIFT = 2;
  localparam int NPINS = 4;

  // Register indices; byte address is index times four
  localparam logic [IDX_W-1:0] IDX_PIN0 = 6'h1d;
  localparam logic [IDX_W-1:0] IDX_PIN12 = 6'h1e;
  localparam logic [IDX_W-1:0] IDX_PIN3 = 6'h1f;
  localparam logic [IDX_W-1:0] IDX_LEVELS = 6'h30;

  // ---------------------------------------------------------------
  // Field layout of one pin nibble
  // ---------------------------------------------------------------
  localparam int BIT_EN = 0;
  localparam int BIT_DIR = 1;
  localparam int BIT_FAR = 2;
  localparam int BIT_VAL = 3;
  localparam int UPPER_NIB = 4;
  localparam int REV_LSB = 4;
  localparam int LEVEL_SEL_BIT = 8;

  // Nibble reset values for primary and alternate port selection
  localparam logic [3:0] NIB_RESET_PRI = 4'h0;
  localparam logic [3:0] NIB_RESET_ALT = 4'h3;

  // {direction, function} codes
  localparam logic [1:0] MODE_FUNC = 2'h0;
  localparam logic [1:0] MODE_GP_OUT = 2'h1;
  localparam logic [1:0] MODE_TRI = 2'h2;
  localparam logic [1:0] MODE_GP_IN = 2'h3;

  // Word index of a byte address
  function automatic logic [IDX_W-1:0] word_index(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:BYTE_SHIFT];
  endfunction

endpackage

/* hw/rcg_pin_drive.sv */
module rcg_pin_drive (
  input wire logic dir_in,
  input wire logic en_in,
  input wire logic far_in,
  input wire logic local_in,
  input wire logic remote_in,
  input wire logic func_in,
  output logic drive_out,
  output logic level_out
);

  // ---------------------------------------------------------------
  // Per-pin decode
  // ---------------------------------------------------------------
  // Remote control overrides whatever the local mode bits say
  always_comb begin
    drive_out = 1'b0;
    level_out = 1'b0;
    if (far_in) begin
      drive_out = 1'b1;
      level_out = remote_in;
    end else begin
      unique case ({dir_in, en_in})
        rcg_pkg::MODE_FUNC: begin
          drive_out = 1'b1;
          level_out = func_in;
        end
        rcg_pkg::MODE_GP_OUT: begin
          drive_out = 1'b1;
          level_out = local_in;
        end
        rcg_pkg::MODE_TRI: begin
          drive_out = 1'b0;
        end
        rcg_pkg::MODE_GP_IN: begin
          drive_out = 1'b0;
        end
      endcase
    end
  end

endmodule

/* hw/rcg_gpio_config.sv */
// Functional notes
// - Direction/function pair: 00 functional out, 10 tri-state, 01 GP out, 11 GP in.
// - Local value drives pin only in GP output mode with remote control off.
// - Remote bit set makes pin an output carrying the link-supplied value.
// - Remote bit clear ignores link values; local settings alone decide.
// - Second-port select routes the configuration to the alternate pin set.
// - With second-port select, direction and function bits reset to one.
// - Bits 7..4 of the pin 0 register return a fixed revision, unwritable.
// - Pin 2 controls sit in the upper nibble, pin 1 in the lower.
//
// Our own choice: the Avalon-MM register port.
module rcg_gpio_config #(
  parameter logic [3:0] REV_CODE = 4'h7 // Arbitrary value
) (
  input wire logic REF_CLK_IN,
  input wire logic SRST_IN,
  input wire logic [rcg_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [rcg_pkg::DATA_W-1:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [rcg_pkg::DATA_W-1:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic SECOND_PORT_SELECT_IN,
  input wire logic [rcg_pkg::NPINS-1:0] REMOTE_VALUE_IN,
  input wire logic [rcg_pkg::NPINS-1:0] FUNC_VALUE_IN,
  input wire logic [rcg_pkg::NPINS-1:0] PRI_PIN_IN,
  output logic [rcg_pkg::NPINS-1:0] PRI_PIN_OUT,
  output logic [rcg_pkg::NPINS-1:0] PRI_PIN_OE_OUT,
  input wire logic [rcg_pkg::NPINS-1:0] ALT_PIN_IN,
  output logic [rcg_pkg::NPINS-1:0] ALT_PIN_OUT,
  output logic [rcg_pkg::NPINS-1:0] ALT_PIN_OE_OUT
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sel_meta;
    logic sel_sync;
    logic [2*rcg_pkg::NPINS-1:0] pin_meta;
    logic [2*rcg_pkg::NPINS-1:0] pin_sync;
    logic [3:0] cfg0;
    logic [7:0] cfg12;
    logic [3:0] cfg3;
    logic waitreq;
    logic [rcg_pkg::DATA_W-1:0] rdata;
    logic [rcg_pkg::NPINS-1:0] pri_out;
    logic [rcg_pkg::NPINS-1:0] pri_oe;
    logic [rcg_pkg::NPINS-1:0] alt_out;
    logic [rcg_pkg::NPINS-1:0] alt_oe;
  } rcg_state_type;

  rcg_state_type st;
  rcg_state_type next_st;
  logic [3:0] nib [rcg_pkg::NPINS];
  logic [rcg_pkg::NPINS-1:0] drive;
  logic [rcg_pkg::NPINS-1:0] level;
  logic [rcg_pkg::IDX_W-1:0] idx;
  logic req;
  logic wr_take;

  // ---------------------------------------------------------------
  // Pin nibbles and drive decode
  // ---------------------------------------------------------------
  // Pin 1 in the low nibble, pin 2 in the upper nibble
  assign nib[0] = st.cfg0;
  assign nib[1] = st.cfg12[rcg_pkg::UPPER_NIB-1:0];
  assign nib[2] = st.cfg12[7:rcg_pkg::UPPER_NIB];
  assign nib[3] = st.cfg3;

  for (genvar i = 0; i < rcg_pkg::NPINS; i++) begin : g_pin
    rcg_pin_drive u_drive (
      .dir_in(nib[i][rcg_pkg::BIT_DIR]),
      .en_in(nib[i][rcg_pkg::BIT_EN]),
      .far_in(nib[i][rcg_pkg::BIT_FAR]),
      .local_in(nib[i][rcg_pkg::BIT_VAL]),
      .remote_in(REMOTE_VALUE_IN[i]),
      .func_in(FUNC_VALUE_IN[i]),
      .drive_out(drive[i]),
      .level_out(level[i])
    );
  end

  // Bus request decode
  assign idx = rcg_pkg::word_index(AVS_ADDRESS_IN);
  assign req = AVS_READ_IN | AVS_WRITE_IN;
  assign wr_take = AVS_WRITE_IN & ~st.waitreq & AVS_BYTEENABLE_IN[0];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // One wait cycle per access keeps read data a clean flop output
  always_comb begin
    next_st = st;
    next_st.sel_meta = SECOND_PORT_SELECT_IN;
    next_st.sel_sync = st.sel_meta;
    next_st.pin_meta = {ALT_PIN_IN, PRI_PIN_IN};
    next_st.pin_sync = st.pin_meta;
    next_st.waitreq = ~(req & st.waitreq);
    if (req && st.waitreq) begin
      next_st.rdata = '0;
      unique case (idx)
        rcg_pkg::IDX_PIN0: next_st.rdata[7:0] = {REV_CODE, st.cfg0};
        rcg_pkg::IDX_PIN12: next_st.rdata[7:0] = st.cfg12;
        rcg_pkg::IDX_PIN3: next_st.rdata[3:0] = st.cfg3; // Upper bits reserved, zero
        rcg_pkg::IDX_LEVELS: begin
          next_st.rdata[2*rcg_pkg::NPINS-1:0] = st.pin_sync;
          next_st.rdata[rcg_pkg::LEVEL_SEL_BIT] = st.sel_sync;
        end
        default: next_st.rdata = '0; // Unmapped reads as zero
      endcase
    end
    // Writes land on the edge where waitrequest is seen low
    if (wr_take) begin
      unique case (idx)
        rcg_pkg::IDX_PIN0: next_st.cfg0 = AVS_WRITEDATA_IN[3:0]; // revision untouched
        rcg_pkg::IDX_PIN12: next_st.cfg12 = AVS_WRITEDATA_IN[7:0];
        rcg_pkg::IDX_PIN3: next_st.cfg3 = AVS_WRITEDATA_IN[3:0];
        default: next_st.cfg3 = st.cfg3; // Unmapped or read-only: ignored
      endcase
    end
    // Only the selected set is driven; the other floats
    if (st.sel_sync) begin
      next_st.alt_oe = drive;
      next_st.alt_out = level & drive;
      next_st.pri_oe = '0;
      next_st.pri_out = '0;
    end else begin
      next_st.pri_oe = drive;
      next_st.pri_out = level & drive;
      next_st.alt_oe = '0;
      next_st.alt_out = '0;
    end
    // Synchronisers keep running so the select is valid at release
    if (SRST_IN) begin
      next_st.cfg0 = st.sel_sync ? rcg_pkg::NIB_RESET_ALT : rcg_pkg::NIB_RESET_PRI;
      next_st.cfg12 = st.sel_sync ? {2{rcg_pkg::NIB_RESET_ALT}} : {2{rcg_pkg::NIB_RESET_PRI}};
      next_st.cfg3 = st.sel_sync ? rcg_pkg::NIB_RESET_ALT : rcg_pkg::NIB_RESET_PRI;
      next_st.waitreq = 1'b1;
      next_st.rdata = '0;
      next_st.pri_out = '0;
      next_st.pri_oe = '0;
      next_st.alt_out = '0;
      next_st.alt_oe = '0;
    end
  end

  // State register
  always_ff @(posedge REF_CLK_IN) begin
    st <= next_st;
  end

  // Outputs straight from the state flops
  assign AVS_READDATA_OUT = st.rdata;
  assign AVS_WAITREQUEST_OUT = st.waitreq;
  assign PRI_PIN_OUT = st.pri_out;
  assign PRI_PIN_OE_OUT = st.pri_oe;
  assign ALT_PIN_OUT = st.alt_out;
  assign ALT_PIN_OE_OUT = st.alt_oe;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (SRST_IN);

  // The functional-mode pin check skips the release edge, whose outputs were still loaded under reset
  func_mode_a: assert property (
    !SRST_IN && !st.sel_sync && nib[0][2:0] == 3'h0
    |=> PRI_PIN_OE_OUT[0] && PRI_PIN_OUT[0] == $past(FUNC_VALUE_IN[0]))
    else $error("functional mode pin 0 not driven with functional value");

  tristate_mode_a: assert property (
    !st.sel_sync && nib[1][2:0] == 3'h2 |=> !PRI_PIN_OE_OUT[1])
    else $error("tri-state pin 1 is driven");

  gpio_input_a: assert property (
    !st.sel_sync && nib[3][2:0] == 3'h3 |=> !PRI_PIN_OE_OUT[3] ##1 !PRI_PIN_OE_OUT[3] || $past(nib[3][2:0]) != 3'h3)
    else $error("input pin 3 is driven or obeys link value");

  local_drive_a: assert property (
    !st.sel_sync && nib[2][2:0] == 3'h1
    |=> PRI_PIN_OE_OUT[2] && PRI_PIN_OUT[2] == $past(nib[2][rcg_pkg::BIT_VAL]))
    else $error("pin 2 not driven with local value");

  remote_drive_a: assert property (
    !st.sel_sync && nib[1][rcg_pkg::BIT_FAR]
    |=> PRI_PIN_OE_OUT[1] && PRI_PIN_OUT[1] == $past(REMOTE_VALUE_IN[1]))
    else $error("remote pin 1 not following link value");

  alt_route_a: assert property (
    !SRST_IN && st.sel_sync |=> PRI_PIN_OE_OUT == '0 && ALT_PIN_OE_OUT == $past(drive))
    else $error("second port selection not routing to alternate pins");

  pri_route_a: assert property (
    !SRST_IN && !st.sel_sync |=> ALT_PIN_OE_OUT == '0 && ALT_PIN_OUT == '0 && PRI_PIN_OE_OUT == $past(drive))
    else $error("primary selection not routing to primary pins");

  reset_default_a: assert property (
    $fell(SRST_IN) |-> st.cfg12 == ($past(st.sel_sync) ? 8'h33 : 8'h00))
    else $error("pin 1/2 reset defaults do not follow select");

  rev_read_a: assert property (
    AVS_READ_IN && st.waitreq && idx == rcg_pkg::IDX_PIN0
    |=> !AVS_WAITREQUEST_OUT && AVS_READDATA_OUT[7:4] == REV_CODE)
    else $error("revision field wrong on read");

  upper_nibble_a: assert property (
    wr_take && idx == rcg_pkg::IDX_PIN12 && AVS_WRITEDATA_IN[7:4] == 4'h1 && !st.sel_sync && !SECOND_PORT_SELECT_IN
    |=> ##1 PRI_PIN_OE_OUT[2] && !PRI_PIN_OUT[2])
    else $error("pin 2 controls not in upper nibble");

  readback_a: assert property (
    wr_take && idx == rcg_pkg::IDX_PIN3 ##2 AVS_READ_IN && idx == rcg_pkg::IDX_PIN3 && st.waitreq
    |=> AVS_READDATA_OUT[7:0] == {4'h0, $past(AVS_WRITEDATA_IN[3:0], 3)})
    else $error("pin 3 readback differs from written value");

  answer_time_a: assert property (
    req && st.waitreq |=> !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT)
    else $error("access not answered after one wait cycle");

  // Waitrequest must stay high while the bus is idle
  idle_wait_a: assert property (
    !req && st.waitreq |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest dropped with no request");

  // A write with byte lane 0 off must leave every nibble untouched
  lane_off_a: assert property (
    AVS_WRITE_IN && !st.waitreq && !AVS_BYTEENABLE_IN[0]
    |=> $stable(st.cfg0) && $stable(st.cfg12) && $stable(st.cfg3))
    else $error("write with byte lane off changed configuration");

  remote_seen_c: cover property (!st.sel_sync && nib[0][rcg_pkg::BIT_FAR] ##1 PRI_PIN_OE_OUT[0]);
  alt_drive_c: cover property (st.sel_sync ##1 ALT_PIN_OE_OUT != '0);
  write_taken_c: cover property (wr_take && idx == rcg_pkg::IDX_PIN12);
  rev_read_c: cover property (AVS_READ_IN && !st.waitreq && idx == rcg_pkg::IDX_PIN0);
  alt_reset_c: cover property ($fell(SRST_IN) && st.cfg12 == 8'h33);

endmodule

/* verif/rcg_far_model.sv */
// ---------------------------------------------------------------
// Far-end serializer: supplies link pin values
// ---------------------------------------------------------------
module rcg_far_model (
  input wire logic clk_in,
  input wire logic load_in,
  input wire logic [3:0] value_in,
  output logic [3:0] remote_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Values arrive one cycle late, as a recovered stream would deliver them
  always_ff @(posedge clk_in) begin
    if (load_in) begin
      remote_out <= value_in;
    end
  end
endmodule

/* verif/remote_capable_gpio_config_tb_top.sv */
module remote_capable_gpio_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] REV = 4'h5; // Arbitrary value
  logic clk, rst, rd, wr, sel, ld, wait_req;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] be, rv, fv, p_in, a_in, far, po, poe, ao, aoe;
  logic [15:0] cfg;
  logic [1:0] ex;
  int fail_count, cmp_count;

  rcg_far_model far_m (.clk_in(clk), .load_in(ld), .value_in(rv), .remote_out(far));
  rcg_gpio_config #(.REV_CODE(REV)) dut (.REF_CLK_IN(clk), .SRST_IN(rst), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_req), .SECOND_PORT_SELECT_IN(sel),
    .REMOTE_VALUE_IN(far), .FUNC_VALUE_IN(fv), .PRI_PIN_IN(p_in), .PRI_PIN_OUT(po),
    .PRI_PIN_OE_OUT(poe), .ALT_PIN_IN(a_in), .ALT_PIN_OUT(ao), .ALT_PIN_OE_OUT(aoe));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Expected {enable, value} of one pin; remote bit overrides the mode pair
  function automatic logic [1:0] exp_pin(input logic [3:0] n, input logic r, input logic f);
    if (n[2]) return {1'b1, r};
    case (n[1:0])
      2'h0: return {1'b1, f};
      2'h1: return {1'b1, n[3]};
      default: return 2'h0;
    endcase
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= {24'h0, d};
    be <= b;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 40);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 40) begin
      fail_count++;
      $display("[ERR] %0t bus timeout", $time);
      end_of_test();
    end
  endtask

  // Write all pin nibbles, read back, then check both pin sets
  task automatic cfg_all(input logic s);
    bus(1'b1, 8'h74, {4'ha, cfg[3:0]}, 4'h1);
    bus(1'b1, 8'h78, cfg[11:4], 4'h1);
    bus(1'b1, 8'h7c, {4'hf, cfg[15:12]}, 4'h1);
    bus(1'b0, 8'h7c, 8'h0, 4'hf);
    chk(q, {28'h0, cfg[15:12]});
    bus(1'b0, 8'h74, 8'h0, 4'hf);
    chk(q, {24'h0, REV, cfg[3:0]});
    bus(1'b0, 8'h78, 8'h0, 4'hf);
    chk(q, {24'h0, cfg[11:4]});
    repeat (2) @(posedge clk);
    #1;
    for (int i = 0; i < 4; i++) begin
      ex = exp_pin(cfg[4*i +: 4], far[i], fv[i]);
      chk({30'h0, s ? aoe[i] : poe[i], s ? ao[i] : po[i]}, {30'h0, ex});
      chk({31'h0, s ? poe[i] : aoe[i]}, 32'h0);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Main sequence: primary pass, then second-port pass
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    sel = 1'b0;
    ld = 1'b1;
    addr = 8'h0;
    wdata = 32'h0;
    be = 4'hf;
    rv = 4'h0;
    fv = 4'h0;
    p_in = 4'h0;
    a_in = 4'h0;
    fail_count = 0;
    cmp_count = 0;
    q = $urandom(96);
    for (int s = 0; s < 2; s++) begin
      // Select is set in the same cycle reset rises, so the synchroniser fills with it before release
      @(posedge clk);
      sel <= s[0];
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 8'h74, 8'h0, 4'hf);
      chk(q, {24'h0, REV, s[0] ? 4'h3 : 4'h0});
      bus(1'b0, 8'h78, 8'h0, 4'hf);
      chk(q, s[0] ? 32'h33 : 32'h0);
      bus(1'b0, 8'h7c, 8'h0, 4'hf);
      chk(q, s[0] ? 32'h3 : 32'h0);
      // Byte lane off and unmapped places must leave no trace
      bus(1'b1, 8'h78, 8'h5a, 4'he);
      bus(1'b0, 8'h78, 8'h0, 4'hf);
      chk(q, s[0] ? 32'h33 : 32'h0);
      bus(1'b1, 8'h00, 8'hff, 4'hf);
      bus(1'b0, 8'h00, 8'h0, 4'hf);
      chk(q, 32'h0);
      // All sixteen nibble codes on every pin, then random mixes
      for (int k = 0; k < 28; k++) begin
        cfg = k < 16 ? {4{k[3:0]}} : 16'($urandom);
        rv <= 4'($urandom);
        fv <= 4'($urandom);
        p_in <= 4'($urandom);
        a_in <= 4'($urandom);
        cfg_all(s[0]);
        bus(1'b0, 8'hc0, 8'h0, 4'hf);
        chk(q, {23'h0, s[0], a_in, p_in});
      end
      $display("test pass %0d done", s);
    end
    end_of_test();
  end
endmodule
